// [pmc_regs.vh]
// Constants for the media configuration and chip condition register pair.
// Assumes a 16-bit management register space reached over the serial management port.
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define PMC_ADDR_PORT_CONFIGURATION 5'h13
`define PMC_ADDR_CHIP_CONDITION 5'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMC_CFG_FIBER_BIT 2
`define PMC_CFG_RSVD_BIT 1
`define PMC_CFG_TXDIS_BIT 0
`define PMC_ST_LINK_BIT 13
`define PMC_ST_DUPLEX_BIT 12
`define PMC_ST_SPEED_BIT 11
`define PMC_ST_ANDONE_BIT 9
`define PMC_ST_PAGE_BIT 8
`define PMC_ST_LOWV_BIT 2

// ----------------------------------------------------------------
// Reset values and frame codes
// ----------------------------------------------------------------
`define PMC_CFG_RSVD_RESET 1'b0
`define PMC_CFG_TXDIS_RESET 1'b0
`define PMC_CFG_FIBER_RESET 1'b0
`define PMC_OP_READ 2'h2
`define PMC_OP_WRITE 2'h1
`define PMC_PREAMBLE_ONES 6'h20
`define PMC_HDR_LAST 4'hc
`define PMC_DATA_LAST 4'hf

`endif

// [pmc_reg_bank.v]
// Holds the media configuration register and composes the chip condition register.
// Assumes write strobes and addresses arrive already decoded from a management frame.
`timescale 1ns/100ps
`include "pmc_regs.vh"

module pmc_reg_bank (
  input wire ref_clk,
  input wire resetn,
  input wire wr_en,
  input wire [4:0] wr_addr,
  input wire [15:0] wr_data,
  input wire [4:0] rd_addr,
  input wire autoneg_enable,
  input wire media_select_strap_pin,
  input wire link_up,
  input wire full_duplex,
  input wire speed_100,
  input wire autoneg_done,
  input wire page_received,
  input wire supply_low_fault,
  output wire [15:0] rd_data,
  output reg fiber_select_q,
  output reg tp_tx_disconnect_q
);

  reg rsvd_q;
  reg strap_done_q;
  reg [15:0] cfg_word;
  reg [15:0] cond_word;

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  // The strap is sampled on the first edge after reset release, since an
  // asynchronous reset may only load constants.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fiber_select_q <= `PMC_CFG_FIBER_RESET;
      rsvd_q <= `PMC_CFG_RSVD_RESET;
      tp_tx_disconnect_q <= `PMC_CFG_TXDIS_RESET;
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      if (!strap_done_q) begin
        fiber_select_q <= autoneg_enable ? 1'b0 : media_select_strap_pin;
      end else if (wr_en && wr_addr == `PMC_ADDR_PORT_CONFIGURATION) begin
        fiber_select_q <= wr_data[`PMC_CFG_FIBER_BIT];
        rsvd_q <= wr_data[`PMC_CFG_RSVD_BIT];
        tp_tx_disconnect_q <= wr_data[`PMC_CFG_TXDIS_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read composition
  // ----------------------------------------------------------------
  // Writes aimed at the condition register land nowhere, so it stays read-only.
  always @* begin
    cfg_word = 16'h0000;
    cfg_word[`PMC_CFG_FIBER_BIT] = fiber_select_q;
    cfg_word[`PMC_CFG_RSVD_BIT] = rsvd_q;
    cfg_word[`PMC_CFG_TXDIS_BIT] = tp_tx_disconnect_q;
    cond_word = 16'h0000;
    cond_word[`PMC_ST_LINK_BIT] = link_up;
    cond_word[`PMC_ST_DUPLEX_BIT] = full_duplex;
    cond_word[`PMC_ST_SPEED_BIT] = speed_100;
    cond_word[`PMC_ST_ANDONE_BIT] = autoneg_done;
    cond_word[`PMC_ST_PAGE_BIT] = page_received;
    cond_word[`PMC_ST_LOWV_BIT] = supply_low_fault;
  end

  assign rd_data = (rd_addr == `PMC_ADDR_PORT_CONFIGURATION) ? cfg_word :
                   (rd_addr == `PMC_ADDR_CHIP_CONDITION) ? cond_word : 16'h0000;

endmodule

// [pmc_top.v]
// Serial management port slave that exposes the media configuration and chip
// condition registers. MDC and MDIO are sampled on ref_clk, so MDC must run
// well below a quarter of ref_clk; the MDIO pin is split into in, out and enable.
`timescale 1ns/100ps
`include "pmc_regs.vh"

module pmc_top (
  input wire ref_clk,
  input wire resetn,
  input wire mdc,
  input wire mdio_in,
  output reg mdio_out_q,
  output reg mdio_oe_q,
  input wire [4:0] phy_address,
  input wire autoneg_enable,
  input wire media_select_strap_pin,
  input wire link_up,
  input wire full_duplex,
  input wire speed_100,
  input wire autoneg_done,
  input wire page_received,
  input wire supply_low_fault,
  output wire fiber_select_q,
  output wire tp_tx_disconnect_q
);

  localparam [3:0] ST_PRE = 4'h1;
  localparam [3:0] ST_HDR = 4'h2;
  localparam [3:0] ST_TA = 4'h4;
  localparam [3:0] ST_DATA = 4'h8;

  reg [3:0] st_q;
  reg mdc_q;
  reg [5:0] pre_q;
  reg [3:0] cnt_q;
  reg [15:0] sr_q;
  reg rd_q;
  reg [4:0] regad_q;
  reg wr_en_q;
  reg [15:0] wr_data_q;
  wire [15:0] rd_data;
  wire mdc_rise;
  wire [12:0] hdr;
  wire hdr_ok;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Moves a word one place towards its top and fills the freed low bit.
  function [15:0] pmc_shift;
    input [15:0] word;
    input bit_in;
    begin
      pmc_shift = {word[14:0], bit_in};
    end
  endfunction

  // Advances a bit counter by one.
  function [3:0] pmc_count_up;
    input [3:0] cnt;
    begin
      pmc_count_up = cnt + 4'h1;
    end
  endfunction

  // True when the opcode asks for the register to be read.
  function pmc_op_is_read;
    input [1:0] op;
    begin
      pmc_op_is_read = (op == `PMC_OP_READ);
    end
  endfunction

  // Only read and write codes are answered; others drop the frame so that a
  // stray pattern never turns the line around.
  function pmc_op_known;
    input [1:0] op;
    begin
      pmc_op_known = pmc_op_is_read(op) || (op == `PMC_OP_WRITE);
    end
  endfunction

  // ----------------------------------------------------------------
  // Clock edge and header view
  // ----------------------------------------------------------------
  assign mdc_rise = mdc & ~mdc_q;
  // Start bit two, opcode, PHY address and register address, oldest first.
  assign hdr = {sr_q[11:0], mdio_in};
  // The frame is ours only if start bit, address and opcode all agree.
  assign hdr_ok = hdr[12] && (hdr[9:5] == phy_address) && pmc_op_known(hdr[11:10]);

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  pmc_reg_bank u_bank (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wr_en(wr_en_q),
    .wr_addr(regad_q),
    .wr_data(wr_data_q),
    .rd_addr(regad_q),
    .autoneg_enable(autoneg_enable),
    .media_select_strap_pin(media_select_strap_pin),
    .link_up(link_up),
    .full_duplex(full_duplex),
    .speed_100(speed_100),
    .autoneg_done(autoneg_done),
    .page_received(page_received),
    .supply_low_fault(supply_low_fault),
    .rd_data(rd_data),
    .fiber_select_q(fiber_select_q),
    .tp_tx_disconnect_q(tp_tx_disconnect_q)
  );

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // Read data is captured whole during turnaround, so a status change mid-frame
  // cannot tear the word the station receives. The second turnaround rise
  // already shows data bit 15, so the station must sample late in each high
  // phase of mdc. A frame cut short by a stopped mdc holds its state and, on a
  // read, keeps driving the line until mdc runs again or reset is applied.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_PRE;
      mdc_q <= 1'b0;
      pre_q <= 6'h00;
      cnt_q <= 4'h0;
      sr_q <= 16'h0000;
      rd_q <= 1'b0;
      regad_q <= 5'h00;
      wr_en_q <= 1'b0;
      wr_data_q <= 16'h0000;
      mdio_out_q <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else begin
      mdc_q <= mdc;
      wr_en_q <= 1'b0;
      if (mdc_rise) begin
        case (st_q)
          ST_PRE: begin
            if (mdio_in) begin
              if (pre_q != `PMC_PREAMBLE_ONES) begin
                pre_q <= pre_q + 6'h01;
              end
            end else begin
              if (pre_q == `PMC_PREAMBLE_ONES) begin
                st_q <= ST_HDR;
                cnt_q <= 4'h0;
              end
              pre_q <= 6'h00;
            end
          end

          ST_HDR: begin
            sr_q <= pmc_shift(sr_q, mdio_in);
            cnt_q <= pmc_count_up(cnt_q);
            if (cnt_q == `PMC_HDR_LAST) begin
              cnt_q <= 4'h0;
              regad_q <= hdr[4:0];
              rd_q <= pmc_op_is_read(hdr[11:10]);
              if (hdr_ok) begin
                st_q <= ST_TA;
              end else begin
                st_q <= ST_PRE;
              end
            end
          end

          ST_TA: begin
            cnt_q <= pmc_count_up(cnt_q);
            if (cnt_q == 4'h0) begin
              if (rd_q) begin
                mdio_oe_q <= 1'b1;
                mdio_out_q <= 1'b0;
                sr_q <= rd_data;
              end
            end else begin
              st_q <= ST_DATA;
              cnt_q <= 4'h0;
              if (rd_q) begin
                mdio_out_q <= sr_q[15];
                sr_q <= pmc_shift(sr_q, 1'b0);
              end
            end
          end

          ST_DATA: begin
            cnt_q <= pmc_count_up(cnt_q);
            if (rd_q) begin
              mdio_out_q <= sr_q[15];
              sr_q <= pmc_shift(sr_q, 1'b0);
            end else begin
              sr_q <= pmc_shift(sr_q, mdio_in);
            end
            if (cnt_q == `PMC_DATA_LAST) begin
              st_q <= ST_PRE;
              cnt_q <= 4'h0;
              mdio_oe_q <= 1'b0;
              mdio_out_q <= 1'b0;
              if (!rd_q) begin
                wr_en_q <= 1'b1;
                wr_data_q <= pmc_shift(sr_q, mdio_in);
              end
            end
          end

          default: begin
            st_q <= ST_PRE;
            mdio_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// [pmc_top_sva.sv]
// Checker for the management port and media outputs of pmc_top.
// Assumes mdc is sampled on ref_clk; bound to every pmc_top instance.
`timescale 1ns/100ps
module pmc_top_sva (
  input wire ref_clk,
  input wire resetn,
  input wire mdc,
  input wire mdio_out_q,
  input wire mdio_oe_q,
  input wire autoneg_enable,
  input wire media_select_strap_pin,
  input wire fiber_select_q,
  input wire tp_tx_disconnect_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_strap_load: assert property ($rose(resetn) |=> fiber_select_q ==
    ($past(autoneg_enable) ? 1'b0 : $past(media_select_strap_pin))) else $error("strap load");
  chk_oe_on_rise: assert property ($changed(mdio_oe_q) |-> $past(mdc) && !$past(mdc, 2))
    else $error("oe moved off an mdc rise");
  chk_out_on_rise: assert property ($changed(mdio_out_q) |-> $past(mdc) && !$past(mdc, 2))
    else $error("data moved off an mdc rise");
  chk_ta_low: assert property ($rose(mdio_oe_q) |-> !mdio_out_q) else $error("turnaround high");
  chk_read_ends: assert property ($rose(mdio_oe_q) |-> ##[1:150] !mdio_oe_q)
    else $error("read drive too long");
  chk_read_gap: assert property ($fell(mdio_oe_q) |-> !mdio_oe_q [*8]) else $error("redrive");
  chk_fiber_write: assert property ($changed(fiber_select_q) && $past(resetn, 2) |->
    $past(mdc, 2) && !$past(mdc, 3)) else $error("fiber changed off a write");
  chk_txdis_write: assert property ($changed(tp_tx_disconnect_q) && $past(resetn, 2) |->
    $past(mdc, 2) && !$past(mdc, 3)) else $error("disconnect changed off a write");
endmodule
bind pmc_top pmc_top_sva u_chk (.ref_clk(ref_clk), .resetn(resetn), .mdc(mdc),
  .mdio_out_q(mdio_out_q), .mdio_oe_q(mdio_oe_q), .autoneg_enable(autoneg_enable),
  .media_select_strap_pin(media_select_strap_pin), .fiber_select_q(fiber_select_q),
  .tp_tx_disconnect_q(tp_tx_disconnect_q));

// [pmc_sta_model.sv]
// Station management model running read and write frames on the MDIO line.
// Assumes the bench resolves the shared line with a pull-up.
`timescale 1ns/100ps
`include "pmc_regs.vh"
module pmc_sta_model (
  input wire ref_clk,
  input wire mdio_line,
  output reg mdc,
  output reg mdio_o,
  output reg mdio_en
);
  initial begin
    mdc = 1'b0;
    mdio_o = 1'b1;
    mdio_en = 1'b0;
  end
  // Three cycles per mdc phase keeps each phase above the two-cycle minimum.
  task bit_io(input b, input en, output s);
    begin
      mdio_o = b;
      mdio_en = en;
      repeat (3) @(negedge ref_clk);
      mdc = 1'b1;
      repeat (3) @(negedge ref_clk);
      s = mdio_line;
      mdc = 1'b0;
    end
  endtask
  task frame(input [1:0] op, input [4:0] ra, input [15:0] wd, output [15:0] rd);
    reg [13:0] hdr;
    reg [17:0] w;
    reg s;
    integer i;
    begin
      hdr = {2'h1, op, 5'h05, ra};
      w = {2'h2, (ra == `PMC_ADDR_PORT_CONFIGURATION) ? (wd & 16'hfffd) : wd};
      rd = 16'h0000;
      for (i = 0; i < 32; i = i + 1) bit_io(1'b1, 1'b1, s);
      for (i = 13; i >= 0; i = i - 1) bit_io(hdr[i], 1'b1, s);
      for (i = 17; i >= 0; i = i - 1) begin
        bit_io(w[i], op != `PMC_OP_READ, s);
        if (i > 0) rd = {rd[14:0], s};
      end
      mdio_en = 1'b0;
      // Let an edge pass so a following frame never re-raises the enable at once.
      @(negedge ref_clk);
    end
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench for pmc_top through the management port model.
// Assumes a pull-up on MDIO and device address 5'h05.
`timescale 1ns/100ps
`include "pmc_regs.vh"
module tb_top;
  reg ref_clk, resetn, autoneg_enable, strap;
  reg [5:0] st;
  reg [15:0] rd;
  integer failures, samples_checked, i;
  integer cyc = 0;
  wire mdc, sta_o, sta_en, dut_o, dut_oe, fiber, txdis;
  wire line = dut_oe ? dut_o : (sta_en ? sta_o : 1'b1);
  pmc_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .mdc(mdc), .mdio_in(line),
    .mdio_out_q(dut_o), .mdio_oe_q(dut_oe), .phy_address(5'h05),
    .autoneg_enable(autoneg_enable), .media_select_strap_pin(strap), .link_up(st[5]),
    .full_duplex(st[4]), .speed_100(st[3]), .autoneg_done(st[2]), .page_received(st[1]),
    .supply_low_fault(st[0]), .fiber_select_q(fiber), .tp_tx_disconnect_q(txdis));
  pmc_sta_model u_sta (.ref_clk(ref_clk), .mdio_line(line), .mdc(mdc), .mdio_o(sta_o),
    .mdio_en(sta_en));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task check(input string name, input [15:0] exp, input [15:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    begin
      u_sta.frame(`PMC_OP_WRITE, a, d, rd);
      repeat (2) @(negedge ref_clk);
    end
  endtask
  task do_reset(input an, input pin);
    begin
      resetn = 1'b0;
      autoneg_enable = an;
      strap = pin;
      repeat (8) @(negedge ref_clk);
      resetn = 1'b1;
      repeat (2) @(negedge ref_clk);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures = failures + 1;
      final_report;
    end
  end
  initial begin
    st = 6'h00;
    failures = 0;
    samples_checked = 0;
    do_reset(1'b0, 1'b1);
    check("fiber", 16'h0001, {15'h0000, fiber});
    u_sta.frame(`PMC_OP_READ, `PMC_ADDR_PORT_CONFIGURATION, 16'h0000, rd);
    check("config", 16'h0004, rd);
    $display("test strap done");
    wr(`PMC_ADDR_PORT_CONFIGURATION, 16'h0001);
    check("txdis", 16'h0001, {15'h0000, txdis});
    check("fiber", 16'h0000, {15'h0000, fiber});
    u_sta.frame(`PMC_OP_READ, `PMC_ADDR_PORT_CONFIGURATION, 16'h0000, rd);
    check("config", 16'h0001, rd);
    wr(`PMC_ADDR_PORT_CONFIGURATION, 16'h0004);
    check("txdis", 16'h0000, {15'h0000, txdis});
    check("fiber", 16'h0001, {15'h0000, fiber});
    u_sta.frame(`PMC_OP_READ, `PMC_ADDR_PORT_CONFIGURATION, 16'h0000, rd);
    check("config", 16'h0004, rd);
    $display("test config done");
    for (i = 0; i < 8; i = i + 1) begin
      st = (i < 6) ? (6'h01 << i) : ((i == 6) ? 6'h3f : 6'h00);
      if (i == 7) wr(`PMC_ADDR_CHIP_CONDITION, 16'hffff);
      u_sta.frame(`PMC_OP_READ, `PMC_ADDR_CHIP_CONDITION, 16'h0000, rd);
      check("status", {2'h0, st[5:3], 1'h0, st[2:1], 5'h00, st[0], 2'h0}, rd);
    end
    u_sta.frame(`PMC_OP_READ, `PMC_ADDR_PORT_CONFIGURATION, 16'h0000, rd);
    check("config after status write", 16'h0004, rd);
    u_sta.frame(`PMC_OP_READ, 5'h1f, 16'h0000, rd);
    check("unmapped", 16'h0000, rd);
    $display("test status done");
    do_reset(1'b1, 1'b1);
    check("fiber", 16'h0000, {15'h0000, fiber});
    $display("test autoneg reset done");
    final_report;
  end
endmodule
